// >>> design/dacr_map.svh
// Register offsets, field positions, reset values and frame counts of the config bank.
`ifndef DACR_MAP_SVH
`define DACR_MAP_SVH
// Register offsets on the serial address byte.
`define DACR_OFF_RST   8'h00
`define DACR_OFF_LOW   8'h20
`define DACR_OFF_REF   8'h3f
`define DACR_OFF_PDM   8'h40
`define DACR_OFF_OIF   8'h41
`define DACR_OFF_EDGE  8'h44
`define DACR_OFF_GNA   8'h55
`define DACR_OFF_FGA   8'h57
`define DACR_OFF_TPA   8'h62
`define DACR_OFF_PEDA  8'h63
`define DACR_OFF_OCB   8'h66
`define DACR_OFF_GNB   8'h68
`define DACR_OFF_FGB   8'h6a
`define DACR_OFF_TPB   8'h75
`define DACR_OFF_PEDB  8'h76
// Writable bits of each register; the rest always read as zero.
`define DACR_MSK_RST   8'h01
`define DACR_MSK_LOW   8'h04
`define DACR_MSK_REF   8'h62
`define DACR_MSK_PDM   8'h0f
`define DACR_MSK_OIF   8'h80
`define DACR_MSK_EDGE  8'hfc
`define DACR_MSK_GN    8'hff
`define DACR_MSK_FG    8'h7f
`define DACR_MSK_TP    8'h07
`define DACR_MSK_PED   8'h3f
`define DACR_MSK_OCB   8'h40
// Storage size and reset value of every register.
`define DACR_NREG      15
`define DACR_REG_RST   8'h00
// Field positions.
`define DACR_SWRST_BIT 7
`define DACR_RDOUT_BIT 0
`define DACR_LOWSP_BIT 2
`define DACR_STBY_BIT  1
`define DACR_LVDS_BIT  7
`define DACR_OCEN_BIT  6
// Power-down mode codes.
`define DACR_PD_PINS   4'h0
`define DACR_PD_NORM   4'h8
`define DACR_PD_BUFB   4'h9
`define DACR_PD_BUFA   4'ha
`define DACR_PD_BUFAB  4'hb
`define DACR_PD_GLOBAL 4'hc
`define DACR_PD_STBYB  4'hd
`define DACR_PD_STBYA  4'he
`define DACR_PD_MUX    4'hf
// Output clock edge codes and their shifts in units of one 26th of the sample period.
`define DACR_EDGE_DLY4 3'h5
`define DACR_EDGE_ADV7 3'h6
`define DACR_EDGE_ADV4 3'h7
`define DACR_SHIFT_P4  4'sh4
`define DACR_SHIFT_M7  (-4'sh7)
`define DACR_SHIFT_M4  (-4'sh4)
// Highest coarse gain code, in half-dB steps.
`define DACR_GAIN_MAX  4'hc
// Serial frame: address bits, then data bits.
`define DACR_ADDR_LAST 5'h07
`define DACR_DATA_LAST 5'h0f
`endif

// >>> design/dacr_pkg.sv
// Types and lookup functions shared by the config bank modules.
`default_nettype none
`include "dacr_map.svh"
package dacr_pkg;
  typedef logic [`DACR_NREG-1:0][7:0] dacr_regs_t;
  typedef struct packed {logic hit; logic [3:0] idx; logic [7:0] mask;} dacr_slot_t;
  typedef struct packed {
    logic [3:0] gainHalfDb; logic [3:0] timeConst; logic [6:0] fineGain;
    logic [2:0] testPat;    logic [5:0] pedestal;
  } dacr_chan_t;
  typedef struct packed {
    logic lowSpeed; logic [1:0] refSel; logic stbyA; logic stbyB;
    logic bufOffA; logic bufOffB; logic globalPd; logic muxMode; logic lvdsSel;
    logic signed [3:0] riseShift; logic signed [3:0] fallShift; logic offCorrEnB;
    dacr_chan_t chanA; dacr_chan_t chanB;
  } dacr_ctrl_t;
  typedef struct packed {logic serialEn_b; logic serialClk; logic serialData;
                         logic [2:0] powerPins;} dacr_pins_t;
  typedef struct packed {
    logic sclkPrev; logic reading; logic [4:0] bitCnt; logic [15:0] shiftIn;
    logic [7:0] shiftOut; logic serial_out_pin; dacr_regs_t regs; dacr_ctrl_t ctrl;
  } dacr_state_t;
  // Maps a serial address to its storage slot and writable mask.
  function automatic dacr_slot_t dacr_slot(input logic [7:0] addr);
    dacr_slot_t s;
    s = '{hit: 1'b0, idx: 4'h0, mask: 8'h00};
    case (addr)
      `DACR_OFF_RST:  s = '{1'b1, 4'h0, `DACR_MSK_RST};
      `DACR_OFF_LOW:  s = '{1'b1, 4'h1, `DACR_MSK_LOW};
      `DACR_OFF_REF:  s = '{1'b1, 4'h2, `DACR_MSK_REF};
      `DACR_OFF_PDM:  s = '{1'b1, 4'h3, `DACR_MSK_PDM};
      `DACR_OFF_OIF:  s = '{1'b1, 4'h4, `DACR_MSK_OIF};
      `DACR_OFF_EDGE: s = '{1'b1, 4'h5, `DACR_MSK_EDGE};
      `DACR_OFF_GNA:  s = '{1'b1, 4'h6, `DACR_MSK_GN};
      `DACR_OFF_FGA:  s = '{1'b1, 4'h7, `DACR_MSK_FG};
      `DACR_OFF_TPA:  s = '{1'b1, 4'h8, `DACR_MSK_TP};
      `DACR_OFF_PEDA: s = '{1'b1, 4'h9, `DACR_MSK_PED};
      `DACR_OFF_OCB:  s = '{1'b1, 4'ha, `DACR_MSK_OCB};
      `DACR_OFF_GNB:  s = '{1'b1, 4'hb, `DACR_MSK_GN};
      `DACR_OFF_FGB:  s = '{1'b1, 4'hc, `DACR_MSK_FG};
      `DACR_OFF_TPB:  s = '{1'b1, 4'hd, `DACR_MSK_TP};
      `DACR_OFF_PEDB: s = '{1'b1, 4'he, `DACR_MSK_PED};
      default:        s = '{1'b0, 4'h0, 8'h00};
    endcase
    return s;
  endfunction : dacr_slot
  // Storage index of a mapped register.
  function automatic logic [3:0] dacr_idx(input logic [7:0] addr);
    dacr_slot_t s;
    s = dacr_slot(addr);
    return s.idx;
  endfunction : dacr_idx
endpackage : dacr_pkg
`default_nettype wire

// >>> design/dacr_pin_sync.sv
// Two-flop synchroniser for the serial and power control pins.
`timescale 1ns/10ps
`default_nettype none
module dacr_pin_sync #(
  parameter int W = 6
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {logic [W-1:0] meta; logic [W-1:0] sync;} dacr_sync_t;
  dacr_sync_t st_r;   // Both stages; only the second stage is ever read.
  dacr_sync_t st_nxt; // Next value of both stages.
  // The first stage feeds the second stage and nothing else.
  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = din;
    st_nxt.sync = st_r.meta;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) st_r <= '0;
    else st_r <= st_nxt;
  end
  assign dout = st_r.sync;
endmodule : dacr_pin_sync
`default_nettype wire

// >>> design/dacr_ctrl_decode.sv
// Decodes the stored register bytes into the converter control word.
`timescale 1ns/10ps
`default_nettype none
module dacr_ctrl_decode import dacr_pkg::*; (
  input  wire dacr_regs_t regs,
  input  wire logic [2:0] pinCode,
  output dacr_ctrl_t      ctrl
);
  logic [3:0] pdCode; // Effective power-down mode after the pin fallback.
  logic [7:0] edgeB;  // Copy of the edge position register.
  // Edge code to signed shift in 26ths of the sample period.
  function automatic logic signed [3:0] edgeShift(input logic [2:0] code);
    case (code)
      `DACR_EDGE_DLY4: return `DACR_SHIFT_P4;
      `DACR_EDGE_ADV7: return `DACR_SHIFT_M7;
      `DACR_EDGE_ADV4: return `DACR_SHIFT_M4;
      default:         return 4'sh0;
    endcase
  endfunction : edgeShift
  // Coarse gain code limited to the 0 to 6 dB range.
  function automatic logic [3:0] gainClamp(input logic [3:0] code);
    return (code > `DACR_GAIN_MAX) ? `DACR_GAIN_MAX : code;
  endfunction : gainClamp
  // Pure decode; the caller registers the result.
  always_comb begin
    ctrl          = '0;
    ctrl.lowSpeed = regs[dacr_idx(`DACR_OFF_LOW)][`DACR_LOWSP_BIT];
    ctrl.refSel   = regs[dacr_idx(`DACR_OFF_REF)][6:5];
    pdCode        = regs[dacr_idx(`DACR_OFF_PDM)][3:0];
    // A cleared field hands the mode to the three pins.
    if (pdCode == `DACR_PD_PINS) pdCode = {1'b1, pinCode};
    case (pdCode)
      `DACR_PD_BUFB:   ctrl.bufOffB = 1'b1;
      `DACR_PD_BUFA:   ctrl.bufOffA = 1'b1;
      `DACR_PD_BUFAB:  {ctrl.bufOffA, ctrl.bufOffB} = 2'b11;
      `DACR_PD_GLOBAL: ctrl.globalPd = 1'b1;
      `DACR_PD_STBYB:  ctrl.stbyB = 1'b1;
      `DACR_PD_STBYA:  ctrl.stbyA = 1'b1;
      default:         ctrl.globalPd = 1'b0;
    endcase
    // Standby keeps reference and buffers alive for a fast wake-up.
    if (regs[dacr_idx(`DACR_OFF_REF)][`DACR_STBY_BIT]) begin
      ctrl.stbyA = 1'b1;
      ctrl.stbyB = 1'b1;
    end
    ctrl.lvdsSel = regs[dacr_idx(`DACR_OFF_OIF)][`DACR_LVDS_BIT];
    // Multiplexing only exists on the parallel CMOS interface.
    ctrl.muxMode = (pdCode == `DACR_PD_MUX) && !ctrl.lvdsSel;
    edgeB          = regs[dacr_idx(`DACR_OFF_EDGE)];
    ctrl.riseShift = edgeShift(edgeB[7:5]);
    ctrl.fallShift = edgeShift(edgeB[4:2]);
    ctrl.offCorrEnB = regs[dacr_idx(`DACR_OFF_OCB)][`DACR_OCEN_BIT];
    ctrl.chanA.gainHalfDb = gainClamp(regs[dacr_idx(`DACR_OFF_GNA)][7:4]);
    ctrl.chanA.timeConst  = regs[dacr_idx(`DACR_OFF_GNA)][3:0];
    ctrl.chanA.fineGain   = regs[dacr_idx(`DACR_OFF_FGA)][6:0];
    ctrl.chanA.testPat    = regs[dacr_idx(`DACR_OFF_TPA)][2:0];
    ctrl.chanA.pedestal   = regs[dacr_idx(`DACR_OFF_PEDA)][5:0];
    ctrl.chanB.gainHalfDb = gainClamp(regs[dacr_idx(`DACR_OFF_GNB)][7:4]);
    ctrl.chanB.timeConst  = regs[dacr_idx(`DACR_OFF_GNB)][3:0];
    ctrl.chanB.fineGain   = regs[dacr_idx(`DACR_OFF_FGB)][6:0];
    ctrl.chanB.testPat    = regs[dacr_idx(`DACR_OFF_TPB)][2:0];
    ctrl.chanB.pedestal   = regs[dacr_idx(`DACR_OFF_PEDB)][5:0];
  end
endmodule : dacr_ctrl_decode
`default_nettype wire

// >>> design/dacr_regbank.sv
// Serial-programmed configuration register bank of the dual-channel converter.
//
// How it works
// - Reset bit restores all registers, self-clears.
// - Readback off: serial output driven low.
// - Readback on: serial output shifts register data.
// - Reference field picks internal or external source.
// - Standby idles both channels, keeps reference, buffers.
// - Zero power-down field defers to three pins.
// - Power-down codes select normal or buffer disables.
// - Power-down codes select global or channel standby.
// - Code 1111 multiplexes channels, CMOS only.
// - Interface bit chooses CMOS or DDR LVDS.
// - Upper edge field shifts one clock edge.
// - Lower edge field shifts the other edge.
// - One write updates all fields of a register.
// - Coarse gain spans 0 to 6 dB.
// - Edge shifts scale with the sample period.
`timescale 1ns/10ps
`default_nettype none
module dacr_regbank import dacr_pkg::*; (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic serialEn_b,
  input  wire logic serialClk,
  input  wire logic serialDataIn,
  input  wire logic powerPinOne,
  input  wire logic powerPinTwo,
  input  wire logic powerPinThree,
  output logic      serialOutPin,
  output dacr_ctrl_t ctrl
);

  // ------------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------------

  dacr_pins_t pinsRaw;  // Pins as they arrive, in another timing domain.
  dacr_pins_t pinsSync; // Pins after two flip-flops.

  // All pins are asynchronous to clk, so none is read before two flops.
  assign pinsRaw = '{serialEn_b: serialEn_b, serialClk: serialClk,
                     serialData: serialDataIn,
                     powerPins: {powerPinThree, powerPinTwo, powerPinOne}};

  dacr_pin_sync #(
    .W ($bits(dacr_pins_t))
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (pinsRaw),
    .dout  (pinsSync)
  );

  // ------------------------------------------------------------------
  // Control decode
  // ------------------------------------------------------------------

  dacr_state_t st_r;    // State of the bank apart from the pin synchroniser flops.
  dacr_state_t st_nxt;  // Next value of the state.
  dacr_ctrl_t  ctrlDec; // Control word decoded from the stored bytes.

  // The decoded word is registered so every output leaves a flip-flop.
  dacr_ctrl_decode u_dec (
    .regs    (st_r.regs),
    .pinCode (pinsSync.powerPins),
    .ctrl    (ctrlDec)
  );

  // ------------------------------------------------------------------
  // Serial frame engine
  // ------------------------------------------------------------------

  logic       sclkRise; // Synchronised serial clock rose this cycle.
  logic       sclkFall; // Synchronised serial clock fell this cycle.
  logic       wrStb;    // A complete write frame is committed this cycle.
  logic [7:0] wrAddr;   // Address of the committed write.
  logic [7:0] wrData;   // Data byte of the committed write.
  logic       rdLoad;   // A read address has just completed.
  logic [7:0] rdAddr;   // Address of the read being started.
  logic [3:0] rdIdx;    // Storage index of the read address.
  dacr_slot_t wrSlot;   // Slot of the write address.
  dacr_slot_t rdSlot;   // Slot of the read address.

  // Frames are sixteen bits, address first, most significant bit first,
  // sampled on rising serial clock edges while the enable is low.
  // Edges are seen a few clk cycles late, so the serial clock must run
  // well below a quarter of clk; that is the price of sampling in clk.
  always_comb begin
    st_nxt          = st_r;
    sclkRise        = pinsSync.serialClk && !st_r.sclkPrev;
    sclkFall        = !pinsSync.serialClk && st_r.sclkPrev;
    st_nxt.sclkPrev = pinsSync.serialClk;
    wrAddr          = st_r.shiftIn[14:7];
    wrData          = {st_r.shiftIn[6:0], pinsSync.serialData};
    rdAddr          = {st_r.shiftIn[6:0], pinsSync.serialData};
    wrSlot          = dacr_slot(wrAddr);
    rdSlot          = dacr_slot(rdAddr);
    rdIdx           = rdSlot.idx;
    wrStb           = 1'b0;
    rdLoad          = 1'b0;

    if (pinsSync.serialEn_b) begin
      // An idle or aborted frame restarts from the first bit.
      st_nxt.bitCnt  = 5'h00;
      st_nxt.reading = 1'b0;
    end else if (sclkRise && st_r.bitCnt <= `DACR_DATA_LAST) begin
      st_nxt.shiftIn = {st_r.shiftIn[14:0], pinsSync.serialData};
      st_nxt.bitCnt  = 5'(st_r.bitCnt + 5'h01);
      // Address complete: with readback on, a nonzero address is a read.
      if (st_r.bitCnt == `DACR_ADDR_LAST &&
          st_r.regs[0][`DACR_RDOUT_BIT] && rdAddr != `DACR_OFF_RST) begin
        rdLoad          = 1'b1;
        st_nxt.reading  = 1'b1;
        // Unmapped addresses read back as zero.
        st_nxt.shiftOut = rdSlot.hit ? st_r.regs[rdIdx] : `DACR_REG_RST;
        st_nxt.serial_out_pin    = st_nxt.shiftOut[7];
      end
      // The last data bit commits a write frame.
      if (st_r.bitCnt == `DACR_DATA_LAST && !st_r.reading) begin
        wrStb = 1'b1;
      end
    end

    // Later read bits change on falling edges, ready for the next rise.
    if (!pinsSync.serialEn_b && sclkFall && st_r.reading &&
        st_r.bitCnt > 5'(`DACR_ADDR_LAST + 5'h01) && st_r.bitCnt <= `DACR_DATA_LAST) begin
      st_nxt.shiftOut = {st_r.shiftOut[6:0], 1'b0};
      st_nxt.serial_out_pin    = st_r.shiftOut[6];
    end

    // Whole byte lands at once; unmapped addresses are ignored.
    if (wrStb && wrSlot.hit) begin
      st_nxt.regs[wrSlot.idx] = wrData & wrSlot.mask;
    end
    // The reset bit is never stored, so it reads back cleared.
    if (wrStb && wrAddr == `DACR_OFF_RST && wrData[`DACR_SWRST_BIT]) begin
      st_nxt.regs = {`DACR_NREG{`DACR_REG_RST}};
    end

    // With readback off the pin is held low rather than released.
    if (!st_nxt.regs[0][`DACR_RDOUT_BIT]) begin
      st_nxt.serial_out_pin = 1'b0;
    end

    st_nxt.ctrl = ctrlDec;
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------

  // All registers start from their reset values.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state flip-flops.
  assign serialOutPin = st_r.serial_out_pin;
  assign ctrl         = st_r.ctrl;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // The last data bit of a frame that sets the software reset bit.
  sequence seqSoftReset;
    wrStb && wrAddr == `DACR_OFF_RST && wrData[`DACR_SWRST_BIT];
  endsequence

  // A mapped write frame commits.
  sequence seqMappedWrite;
    wrStb && wrSlot.hit && !(wrAddr == `DACR_OFF_RST && wrData[`DACR_SWRST_BIT]);
  endsequence

  chk_soft_reset_all: assert property (seqSoftReset |=> st_r.regs == '0)
    else $error("software reset left a register set");

  chk_serial_out_pin_low: assert property (!st_r.regs[0][`DACR_RDOUT_BIT] |-> !serialOutPin)
    else $error("serial output not low with readback off");

  // The hit flag is taken from the load cycle; a cycle later the address bits have moved on.
  chk_read_first_bit: assert property (rdLoad |=> serialOutPin == st_r.shiftOut[7]
    && st_r.shiftOut == ($past(rdSlot.hit) ? st_r.regs[$past(rdIdx)] : 8'h00))
    else $error("read did not present the register msb");

  chk_write_whole: assert property (seqMappedWrite |=>
    st_r.regs[$past(wrSlot.idx)] == ($past(wrData) & $past(wrSlot.mask)))
    else $error("write did not update the whole register");

  chk_standby_both: assert property (st_r.regs[2][`DACR_STBY_BIT] |=>
    ctrl.stbyA && ctrl.stbyB)
    else $error("standby bit did not idle both channels");

  chk_ref_select: assert property (##1 ctrl.refSel == $past(st_r.regs[2][6:5]))
    else $error("reference selection does not follow its field");

  chk_pins_control: assert property (st_r.regs[3][3:0] == `DACR_PD_PINS &&
    pinsSync.powerPins == 3'h4 |=> ctrl.globalPd)
    else $error("pins did not control power-down");

  chk_buf_both_off: assert property (st_r.regs[3][3:0] == `DACR_PD_BUFAB |=>
    ctrl.bufOffA && ctrl.bufOffB && !ctrl.globalPd)
    else $error("both buffers not disabled");

  chk_stby_chan_b: assert property (st_r.regs[3][3:0] == `DACR_PD_STBYB &&
    !st_r.regs[2][`DACR_STBY_BIT] |=> ctrl.stbyB && !ctrl.stbyA)
    else $error("channel b standby decode wrong");

  chk_mux_cmos: assert property (ctrl.muxMode |-> !ctrl.lvdsSel)
    else $error("multiplexed mode with lvds selected");

  // The code on its own must also switch the mode on while CMOS is selected.
  chk_mux_enable: assert property (st_r.regs[3][3:0] == `DACR_PD_MUX &&
    !st_r.regs[4][`DACR_LVDS_BIT] |=> ctrl.muxMode)
    else $error("multiplexed mode not enabled on cmos");

  chk_lvds_select: assert property (##1 ctrl.lvdsSel == $past(st_r.regs[4][7]))
    else $error("interface select does not follow its bit");

  chk_edge_advance: assert property (st_r.regs[5][7:5] == `DACR_EDGE_ADV7 |=>
    ctrl.riseShift == -4'sh7)
    else $error("upper edge field advance wrong");

  chk_edge_delay: assert property (st_r.regs[5][4:2] == `DACR_EDGE_DLY4 |=>
    ctrl.fallShift == 4'sh4)
    else $error("lower edge field delay wrong");

  chk_gain_range: assert property (ctrl.chanB.gainHalfDb <= 4'hc)
    else $error("coarse gain above 6 dB");

endmodule : dacr_regbank
`default_nettype wire

// >>> verif/dacr_host_model.sv
// Host model that drives the serial programming pins of the config bank.
`timescale 1ns/10ps
`default_nettype none
module dacr_host_model (
  input  wire logic clk,
  output logic      serialEn_b,
  output logic      serialClk,
  output logic      serialDataIn,
  input  wire logic serialOutPin
);
  // ------------------------------------------------------------------
  // Idle levels and the frame task
  // ------------------------------------------------------------------
  // The serial clock stands still outside frames.
  initial begin
    serialEn_b   = 1'b1;
    serialClk    = 1'b0;
    serialDataIn = 1'b0;
  end

  // Sends address then data, MSB first, six clocks per phase for sync margin.
  // Read bits are taken just before rises 9 to 16, where the bank has settled them.
  task automatic frame(input logic [7:0] addr, input logic [7:0] data,
                       input logic [7:0] mask, output logic [7:0] rdata);
    logic [15:0] word;
    word  = {addr, data & mask};
    rdata = 8'h00;
    @(posedge clk) serialEn_b <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serialDataIn <= word[i];
      repeat (6) @(posedge clk);
      if (i < 8) begin
        rdata[i] = serialOutPin;
      end
      serialClk <= 1'b1;
      repeat (6) @(posedge clk);
      serialClk <= 1'b0;
    end
    repeat (6) @(posedge clk);
    serialEn_b   <= 1'b1;
    // A released data line must not keep showing the last bit.
    serialDataIn <= ~word[0];
    repeat (6) @(posedge clk);
  endtask : frame
endmodule : dacr_host_model
`default_nettype wire

// >>> verif/dacr_regbank_bench.sv
// Self-checking bench for the serial config register bank.
`timescale 1ns/10ps
`default_nettype none
`include "dacr_map.svh"
module dacr_regbank_bench import dacr_pkg::*;;
  logic       clk = 1'b0;  // Bench clock, 8 ns period.
  logic       rst_b = 1'b0; // Async reset, active low.
  logic [2:0] pins = 3'h0;  // Power pin code {three, two, one}.
  logic       rdEn = 1'b0;  // Expected readback enable.
  wire logic  serialEn_b;
  wire logic  serialClk;
  wire logic  serialDataIn;
  logic       serialOutPin;
  dacr_ctrl_t ctrl;
  int         numErrors = 0;
  int         totalChecks = 0;

  always #4 clk = ~clk;

  dacr_host_model host (.clk(clk), .serialEn_b(serialEn_b), .serialClk(serialClk),
                        .serialDataIn(serialDataIn), .serialOutPin(serialOutPin));
  dacr_regbank DUT (.clk(clk), .rst_b(rst_b), .serialEn_b(serialEn_b),
                    .serialClk(serialClk), .serialDataIn(serialDataIn),
                    .powerPinOne(pins[0]), .powerPinTwo(pins[1]),
                    .powerPinThree(pins[2]), .serialOutPin(serialOutPin), .ctrl(ctrl));

  // ------------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    totalChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic stopTest();
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stopTest

  // Readback off means a driven low, checked away from the clock edge.
  always @(negedge clk) begin
    if (rst_b && !rdEn) begin
      check("serialOutPin idle", 8'h00, {7'h0, serialOutPin});
    end
  end

  // Power state as {globalPd, stbyA, stbyB, bufOffA, bufOffB, muxMode}.
  function automatic logic [5:0] expPd(input logic [3:0] f, input logic [2:0] p,
                                       input logic lv, input logic sb);
    logic [3:0] c;
    logic [5:0] e;
    c = (f == 4'h0) ? {1'b1, p} : f;
    e = 6'h00;
    case (c)
      4'h9: e[1] = 1'b1;
      4'ha: e[2] = 1'b1;
      4'hb: e[2:1] = 2'b11;
      4'hc: e[5] = 1'b1;
      4'hd: e[3] = 1'b1;
      4'he: e[4] = 1'b1;
      4'hf: e[0] = ~lv;
      default: e = 6'h00;
    endcase
    e[4:3] = e[4:3] | {sb, sb};
    return e;
  endfunction : expPd

  // Edge shift in 26ths of the sample period, two's complement.
  function automatic logic [3:0] expShift(input logic [2:0] c);
    case (c)
      3'h5: return 4'h4;
      3'h6: return 4'h9;
      3'h7: return 4'hc;
      default: return 4'h0;
    endcase
  endfunction : expShift

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
    logic [7:0] u;
    host.frame(a, d, m, u);
  endtask : wr

  // A read needs readback on, and readback is dropped again afterwards.
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    logic [7:0] u;
    rdEn = 1'b1;
    host.frame(8'h00, 8'h01, 8'hff, u);
    host.frame(a, 8'h00, 8'h00, r);
    host.frame(8'h00, 8'h00, 8'hff, u);
    rdEn = 1'b0;
  endtask : rd

  function automatic logic [5:0] seenPd();
    return {ctrl.globalPd, ctrl.stbyA, ctrl.stbyB, ctrl.bufOffA, ctrl.bufOffB, ctrl.muxMode};
  endfunction : seenPd

  // Control field driven by round-trip slot i, laid out as its register byte.
  function automatic logic [7:0] seenField(input int i);
    case (i)
      5:       return {ctrl.chanA.gainHalfDb, ctrl.chanA.timeConst};
      6:       return {1'b0, ctrl.chanA.fineGain};
      7:       return {5'h00, ctrl.chanA.testPat};
      8:       return {2'h0, ctrl.chanA.pedestal};
      9:       return {1'b0, ctrl.offCorrEnB, 6'h00};
      10:      return {ctrl.chanB.gainHalfDb, ctrl.chanB.timeConst};
      11:      return {1'b0, ctrl.chanB.fineGain};
      12:      return {5'h00, ctrl.chanB.testPat};
      13:      return {2'h0, ctrl.chanB.pedestal};
      default: return 8'h00;
    endcase
  endfunction : seenField

  // Expected field byte; coarse gain above 6 dB is limited to 6 dB.
  function automatic logic [7:0] expField(input int i, input logic [7:0] v);
    logic [7:0] e;
    e = (i >= 5 && i <= 13) ? v : 8'h00;
    if ((i == 5 || i == 10) && e[7:4] > 4'hc) begin
      e[7:4] = 4'hc;
    end
    return e;
  endfunction : expField

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin : mainSeq
    logic [7:0] ad[15];
    logic [7:0] mk[15];
    logic [7:0] r;
    logic [7:0] d;
    logic [3:0] t;
    logic       lv;
    logic       sb;
    logic [1:0] rf;
    ad = '{8'h20, 8'h3f, 8'h40, 8'h41, 8'h44, 8'h55, 8'h57, 8'h62, 8'h63, 8'h66,
           8'h68, 8'h6a, 8'h75, 8'h76, 8'h21};
    mk = '{`DACR_MSK_LOW, `DACR_MSK_REF, `DACR_MSK_PDM, `DACR_MSK_OIF, `DACR_MSK_EDGE,
           `DACR_MSK_GN, `DACR_MSK_FG, `DACR_MSK_TP, `DACR_MSK_PED, `DACR_MSK_OCB,
           `DACR_MSK_GN, `DACR_MSK_FG, `DACR_MSK_TP, `DACR_MSK_PED, 8'h00};
    d = 8'($urandom(67467));
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    // Round trip of every register but the reset one at 00; the last address is unmapped and reads zero.
    for (int i = 0; i < 15; i++) begin
      d = 8'($urandom);
      wr(ad[i], d, (mk[i] == 8'h00) ? 8'hff : mk[i]);
      rd(ad[i], r);
      check("readback", d & mk[i], r);
      check("ctrl field", expField(i, d & mk[i]), seenField(i));
    end
    // Every power code, random interface (CMOS for code 1111), reference and standby settings.
    for (int c = 0; c < 16; c++) begin
      lv = (c == 15) ? 1'b0 : 1'($urandom);
      sb = 1'($urandom);
      rf = 2'($urandom);
      @(posedge clk) pins <= 3'($urandom);
      wr(8'h41, {lv, 7'h0}, 8'hff);
      wr(8'h3f, {1'b0, rf, 3'h0, sb, 1'b0}, 8'hff);
      wr(8'h40, 8'(c), 8'hff);
      check("lvdsSel", {7'h0, lv}, {7'h0, ctrl.lvdsSel});
      check("refSel", {6'h0, rf}, {6'h0, ctrl.refSel});
      check("power", {2'b0, expPd(4'(c), pins, lv, sb)}, {2'b0, seenPd()});
    end
    // Field zero hands the choice to the pins, all eight codes.
    wr(8'h3f, 8'h00, 8'hff);
    wr(8'h41, 8'h00, 8'hff);
    wr(8'h40, 8'h00, 8'hff);
    for (int p = 0; p < 8; p++) begin
      @(posedge clk) pins <= 3'(p);
      repeat (8) @(posedge clk);
      check("pin power", {2'b0, expPd(4'h0, 3'(p), 1'b0, 1'b0)}, {2'b0, seenPd()});
    end
    // Both edge fields always get the same code.
    for (int c = 0; c < 8; c++) begin
      wr(8'h44, {3'(c), 3'(c), 2'b00}, 8'hff);
      check("riseShift", {4'h0, expShift(3'(c))}, {4'h0, ctrl.riseShift});
      check("fallShift", {4'h0, expShift(3'(c))}, {4'h0, ctrl.fallShift});
    end
    // Coarse gain and loop time land together from one write.
    for (int g = 0; g < 16; g++) begin
      t = 4'($urandom);
      wr(8'h68, {4'(g), t}, 8'hff);
      check("gain", (g > 12) ? 8'h0c : 8'(g), {4'h0, ctrl.chanB.gainHalfDb});
      check("timeConst", {4'h0, t}, {4'h0, ctrl.chanB.timeConst});
    end
    // Low speed is only set for a slow sample rate.
    wr(8'h20, 8'h04, 8'hff);
    check("lowSpeed", 8'h01, {7'h0, ctrl.lowSpeed});
    // Software reset clears everything and leaves no bit behind.
    wr(8'h00, 8'h80, 8'hff);
    check("lowSpeed reset", 8'h00, {7'h0, ctrl.lowSpeed});
    rd(8'h68, r);
    check("gain reg reset", 8'h00, r);
    stopTest();
  end

  // Cuts a hang short; the sequence needs about 29000 cycles.
  initial begin : watchdog
    repeat (80000) @(posedge clk);
    numErrors++;
    stopTest();
  end
endmodule : dacr_regbank_bench
`default_nettype wire
